/* logic/ovps_pkg.sv */
// Purpose: Constants and types shared by the overvoltage pick-up stage files
// Assumes: APB slave with 32-bit data, one word per register
// Notes: Thresholds are in units of 0.01 percent of nominal voltage
package ovps_pkg;

    localparam int unsigned n_stages = 4;
    localparam int unsigned n_groups = 8;
    localparam int unsigned mag_w = 16;

    // Register byte offsets
    localparam logic [7:0] off_global = 8'h00;
    localparam logic [7:0] off_group_sel = 8'h04;
    localparam logic [7:0] off_wiring = 8'h08;
    localparam logic [7:0] off_irq_status = 8'h0c;
    localparam logic [7:0] off_irq_enable = 8'h10;
    localparam logic [7:0] off_irq_clear = 8'h14;
    localparam logic [7:0] off_stage_status = 8'h18;
    localparam logic [7:0] off_stage_base = 8'h40;
    localparam logic [7:0] off_group_base = 8'h80;

    // Global register fields
    localparam int unsigned bit_mode_allow = 0;
    localparam int unsigned bit_force_enable = 1;

    // Stage static register fields: [2:0] mode, [5:4] forced, [9:8] source
    localparam int unsigned pos_mode = 0;
    localparam int unsigned pos_forced = 4;
    localparam int unsigned pos_source = 8;

    // Group setting word: [15:0] threshold, [17:16] criterion
    localparam int unsigned pos_criterion = 16;

    localparam logic [15:0] threshold_reset = 16'h2904;
    localparam logic [6:0] release_pct = 7'h61;
    localparam logic [6:0] hundred_pct = 7'h64;

    // Magnitude refresh interval and cycles at 200 MHz
    localparam int unsigned refresh_ms = 5;
    localparam int unsigned clock_mhz = 200;
    localparam int unsigned refresh_cycles = refresh_ms * clock_mhz * 1000;

    typedef enum logic [2:0] {
        mode_on,
        mode_blocked,
        mode_test,
        mode_test_blocked,
        mode_off
    } ovps_mode_type;

    typedef enum logic [1:0] {
        status_normal,
        status_start,
        status_trip,
        status_blocked
    } ovps_status_type;

    typedef enum logic [1:0] {
        src_phase_phase,
        src_phase_earth,
        src_channel3,
        src_channel4
    } ovps_source_type;

    typedef enum logic [1:0] {
        crit_one = 2'h0,
        crit_two = 2'h1,
        crit_three = 2'h2
    } ovps_crit_type;

    typedef struct packed {
        ovps_mode_type stage_operating_mode;
        ovps_status_type forced_stage_status;
        ovps_source_type source;
    } ovps_static_type;

    typedef struct packed {
        ovps_crit_type criterion;
        logic [15:0] threshold;
    } ovps_group_type;

    // Eight magnitudes: line-line 12/23/31, line-neutral 1/2/3, channel 3, channel 4
    typedef struct packed {
        logic [mag_w-1:0] ll12;
        logic [mag_w-1:0] ll23;
        logic [mag_w-1:0] ll31;
        logic [mag_w-1:0] ln1;
        logic [mag_w-1:0] ln2;
        logic [mag_w-1:0] ln3;
        logic [mag_w-1:0] ch3;
        logic [mag_w-1:0] ch4;
    } ovps_meas_type;

endpackage

/* logic/ovps_group_mem.sv */
// Purpose: Setting-group memory holding threshold and criterion per stage and group
// Assumes: One write port, one read port, registered read data
// Notes: Reset restores every entry to default criterion and threshold
`timescale 1ns/1ps
module ovps_group_mem #(
    parameter int unsigned depth = 32,
    parameter int unsigned aw = 5
) (
    input wire logic clock, // System clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic wr_en, // Write strobe
    input wire logic [aw-1:0] wr_addr, // Write index
    input wire ovps_pkg::ovps_group_type wr_data, // Write word
    input wire logic [aw-1:0] rd_addr, // Read index
    output ovps_pkg::ovps_group_type rd_data // Registered read word
);
    ovps_pkg::ovps_group_type mem_reg [depth];

    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < depth; i++) begin
                mem_reg[i] <= '{criterion: ovps_pkg::crit_one,
                                threshold: ovps_pkg::threshold_reset};
            end
        end else if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rd_data <= '{criterion: ovps_pkg::crit_one, threshold: ovps_pkg::threshold_reset};
        end else begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule

/* logic/ovps_stage.sv */
// Purpose: Four overvoltage pick-up stages with APB settings and interrupt
// Assumes: Magnitudes arrive on this clock with a new-sample strobe every 5 ms
// Notes: Trip timing and external blocking are outside this block
//
// What this block does
// - Four independent stages, each with its own settings and pick-up logic.
// - Inputs are fundamental line or phase magnitudes, refreshed every 5 ms.
// - Source picks line-line, line-earth, channel 3 or channel 4; reset is line-line.
// - Line-line and line-earth use channels 1-3, only 1-2 in two-line-aux wiring.
// - Channel 4 is always watched; channel 3 only in two-line-aux wiring.
// - Mode is On, Blocked, Test, Test/Blocked or Off, resets On, writable if allowed.
// - Forced status is Normal, Start, Trip or Blocked, resets Normal, needs forcing on.
// - Mode and forced status are static, outside the setting groups.
// - Three magnitudes are over when above one common threshold.
// - A picked-up voltage releases only below 97 percent of the threshold.
// - Pick-up needs one, two or three voltages over, per criterion, reset one.
// - Threshold steps are 0.01 percent of nominal, reset 105 percent.
// - Threshold and criterion follow the active group and may change while running.
`timescale 1ns/1ps
module ovps_stage #(
    parameter int unsigned refresh_cycles = ovps_pkg::refresh_cycles
) (
    input wire logic clock, // 200 MHz system clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire ovps_pkg::ovps_meas_type measured_magnitude, // Magnitudes, percent of nominal x100
    input wire logic meas_valid, // One-cycle strobe for a new sample set
    output logic [7:0] stage_status, // Two status bits per stage
    output logic [3:0] stage_pickup, // Computed pick-up per stage
    output logic irq // Level interrupt
);
    localparam int unsigned cw = $clog2(2 * refresh_cycles + 1);

    ovps_pkg::ovps_static_type static_reg [ovps_pkg::n_stages];
    ovps_pkg::ovps_meas_type meas_reg;
    logic mode_allow_reg;
    logic force_enable_reg;
    logic two_line_aux_wiring;
    logic [2:0] group_sel_reg;
    logic [3:0] pickup_reg;
    logic [2:0] over_reg [ovps_pkg::n_stages];
    logic [7:0] irq_status_reg;
    logic [7:0] irq_enable_reg;
    logic [7:0] irq_event;
    logic [1:0] eval_stage_reg;
    logic eval_busy_reg;
    logic eval_load_reg;
    logic [cw-1:0] stale_cnt_reg;
    logic stale_reg;
    logic [31:0] prdata_next;
    logic map_hit;
    logic apb_wr;
    logic apb_rd;
    logic mem_wr;
    ovps_pkg::ovps_group_type mem_rd_data;
    ovps_pkg::ovps_group_type mem_wr_data;
    logic [4:0] mem_rd_addr;

    // Scale threshold by a percentage, kept in 32 bits to avoid overflow
    function automatic logic [31:0] scale_pct(input logic [15:0] thr, input logic [6:0] pct);
        scale_pct = 32'(thr) * 32'(pct);
    endfunction

    function automatic logic [1:0] count3(input logic [2:0] v);
        count3 = 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
    endfunction

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign pready = psel && penable;
    assign mem_wr = apb_wr && paddr[7];
    assign mem_wr_data = '{criterion: ovps_pkg::ovps_crit_type'(pwdata[17:16]),
                           threshold: pwdata[15:0]};

    // Setting groups: index is group * 4 + stage
    assign mem_rd_addr = eval_busy_reg ? {group_sel_reg[2:0] , eval_stage_reg}
                                       : paddr[6:2];

    ovps_group_mem #(
        .depth(ovps_pkg::n_groups * ovps_pkg::n_stages),
        .aw(5)
    ) u_group_mem (
        .clock(clock),
        .rstn(rstn),
        .wr_en(mem_wr),
        .wr_addr(paddr[6:2]),
        .wr_data(mem_wr_data),
        .rd_addr(mem_rd_addr),
        .rd_data(mem_rd_data)
    );

    // Global permissions, wiring and group select
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mode_allow_reg <= 1'b0;
            force_enable_reg <= 1'b0;
            two_line_aux_wiring <= 1'b0;
            group_sel_reg <= 3'h0;
        end else if (apb_wr) begin
            if (paddr == ovps_pkg::off_global) begin
                mode_allow_reg <= pwdata[ovps_pkg::bit_mode_allow];
                force_enable_reg <= pwdata[ovps_pkg::bit_force_enable];
            end
            if (paddr == ovps_pkg::off_group_sel) begin
                group_sel_reg <= pwdata[2:0];
            end
            if (paddr == ovps_pkg::off_wiring) begin
                two_line_aux_wiring <= pwdata[0];
            end
        end
    end

    // Static per-stage settings, independent of the group select
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int s = 0; s < ovps_pkg::n_stages; s++) begin
                static_reg[s] <= '{stage_operating_mode: ovps_pkg::mode_on,
                                   forced_stage_status: ovps_pkg::status_normal,
                                   source: ovps_pkg::src_phase_phase};
            end
        end else if (apb_wr && paddr[7:4] == 4'h4) begin
            static_reg[paddr[3:2]].source <=
                ovps_pkg::ovps_source_type'(pwdata[ovps_pkg::pos_source +: 2]);
            if (mode_allow_reg && pwdata[ovps_pkg::pos_mode +: 3] <= 3'h4) begin
                static_reg[paddr[3:2]].stage_operating_mode <=
                    ovps_pkg::ovps_mode_type'(pwdata[ovps_pkg::pos_mode +: 3]);
            end
            if (force_enable_reg) begin
                static_reg[paddr[3:2]].forced_stage_status <=
                    ovps_pkg::ovps_status_type'(pwdata[ovps_pkg::pos_forced +: 2]);
            end
        end
    end

    // Latch a fresh sample set and walk the stages through the group memory
    always_ff @(posedge clock) begin
        if (!rstn) begin
            meas_reg <= '0;
            eval_busy_reg <= 1'b0;
            eval_load_reg <= 1'b0;
            eval_stage_reg <= 2'h0;
        end else begin
            eval_load_reg <= eval_busy_reg;
            if (meas_valid && !eval_busy_reg) begin
                meas_reg <= measured_magnitude;
                eval_busy_reg <= 1'b1;
                eval_stage_reg <= 2'h0;
            end else if (eval_busy_reg) begin
                eval_stage_reg <= eval_stage_reg + 2'h1;
                if (eval_stage_reg == 2'h3) begin
                    eval_busy_reg <= 1'b0;
                end
            end
        end
    end

    // Per-stage comparison one cycle after the memory read
    logic [1:0] cmp_stage_reg;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cmp_stage_reg <= 2'h0;
        end else begin
            cmp_stage_reg <= eval_stage_reg;
        end
    end

    logic [ovps_pkg::mag_w-1:0] sel_mag [3];
    logic [2:0] sel_used;
    logic [2:0] over_next;
    logic pick_next;

    always_comb begin
        sel_used = 3'h7;
        sel_mag[0] = meas_reg.ll12;
        sel_mag[1] = meas_reg.ll23;
        sel_mag[2] = meas_reg.ll31;
        case (static_reg[cmp_stage_reg].source)
            ovps_pkg::src_phase_phase: begin
                sel_mag[0] = meas_reg.ll12;
            end
            ovps_pkg::src_phase_earth: begin
                sel_mag[0] = meas_reg.ln1;
                sel_mag[1] = meas_reg.ln2;
                sel_mag[2] = meas_reg.ln3;
            end
            ovps_pkg::src_channel3: begin
                sel_mag[0] = meas_reg.ch3;
                sel_used = two_line_aux_wiring ? 3'h1 : 3'h0;
            end
            ovps_pkg::src_channel4: begin
                sel_mag[0] = meas_reg.ch4;
                sel_used = 3'h1;
            end
            default: begin
                sel_used = 3'h0;
            end
        endcase
        // Two-line wiring has no third line channel
        if (two_line_aux_wiring && static_reg[cmp_stage_reg].source inside
                {ovps_pkg::src_phase_phase, ovps_pkg::src_phase_earth}) begin
            sel_used = 3'h3;
        end
        for (int i = 0; i < 3; i++) begin
            // Hysteresis: compare 100*mag against 97*thr so no division is needed
            if (!sel_used[i]) begin
                over_next[i] = 1'b0;
            end else if (over_reg[cmp_stage_reg][i]) begin
                over_next[i] = scale_pct(sel_mag[i][15:0], ovps_pkg::hundred_pct) >=
                    scale_pct(mem_rd_data.threshold, ovps_pkg::release_pct);
            end else begin
                over_next[i] = sel_mag[i] > mem_rd_data.threshold;
            end
        end
        case (mem_rd_data.criterion)
            ovps_pkg::crit_two: pick_next = count3(over_next) >= 2'h2;
            ovps_pkg::crit_three: pick_next = count3(over_next) == 2'h3 &&
                sel_used == 3'h7;
            default: pick_next = count3(over_next) >= 2'h1;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            pickup_reg <= 4'h0;
            for (int s = 0; s < ovps_pkg::n_stages; s++) begin
                over_reg[s] <= 3'h0;
            end
        end else if (eval_load_reg) begin
            over_reg[cmp_stage_reg] <= over_next;
            pickup_reg[cmp_stage_reg] <= pick_next && !stale_reg;
        end else if (stale_reg) begin
            pickup_reg <= 4'h0;
        end
    end

    // A missing refresh drops pick-up rather than holding a stale decision
    always_ff @(posedge clock) begin
        if (!rstn) begin
            stale_cnt_reg <= '0;
            stale_reg <= 1'b0;
        end else if (meas_valid) begin
            stale_cnt_reg <= '0;
            stale_reg <= 1'b0;
        end else if (stale_cnt_reg == cw'(2 * refresh_cycles)) begin
            stale_reg <= 1'b1;
        end else begin
            stale_cnt_reg <= stale_cnt_reg + cw'(1);
        end
    end

    // Status per stage: forced value wins, then mode, then pick-up
    logic [7:0] status_next;
    always_comb begin
        for (int s = 0; s < ovps_pkg::n_stages; s++) begin
            if (force_enable_reg &&
                    static_reg[s].forced_stage_status != ovps_pkg::status_normal) begin
                status_next[2*s +: 2] = static_reg[s].forced_stage_status;
            end else if (static_reg[s].stage_operating_mode == ovps_pkg::mode_off) begin
                status_next[2*s +: 2] = ovps_pkg::status_normal;
            end else if (static_reg[s].stage_operating_mode inside
                    {ovps_pkg::mode_blocked, ovps_pkg::mode_test_blocked}) begin
                status_next[2*s +: 2] = pickup_reg[s] ? ovps_pkg::status_blocked
                                                      : ovps_pkg::status_normal;
            end else begin
                status_next[2*s +: 2] = pickup_reg[s] ? ovps_pkg::status_start
                                                      : ovps_pkg::status_normal;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            stage_status <= 8'h00;
            stage_pickup <= 4'h0;
        end else begin
            stage_status <= status_next;
            stage_pickup <= pickup_reg;
        end
    end

    // Events: pick-up rise in bits 3:0, pick-up fall in bits 7:4
    assign irq_event = {stage_pickup & ~pickup_reg, pickup_reg & ~stage_pickup};

    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_status_reg <= 8'h00;
            irq_enable_reg <= 8'h00;
        end else begin
            // A new event wins over a clear in the same cycle
            if (apb_wr && paddr == ovps_pkg::off_irq_clear) begin
                irq_status_reg <= (irq_status_reg & ~pwdata[7:0]) | irq_event;
            end else begin
                irq_status_reg <= irq_status_reg | irq_event;
            end
            if (apb_wr && paddr == ovps_pkg::off_irq_enable) begin
                irq_enable_reg <= pwdata[7:0];
            end
        end
    end

    assign irq = |(irq_status_reg & irq_enable_reg);

    // Read mux; group words read back as zero since the memory port serves evaluation
    always_comb begin
        prdata_next = 32'h0;
        map_hit = 1'b1;
        if (paddr[7:4] == 4'h4) begin
            prdata_next[ovps_pkg::pos_mode +: 3] = static_reg[paddr[3:2]].stage_operating_mode;
            prdata_next[ovps_pkg::pos_forced +: 2] = static_reg[paddr[3:2]].forced_stage_status;
            prdata_next[ovps_pkg::pos_source +: 2] = static_reg[paddr[3:2]].source;
        end else if (paddr[7]) begin
            prdata_next = 32'h0;
        end else begin
            case (paddr)
                ovps_pkg::off_global: prdata_next[1:0] = {force_enable_reg, mode_allow_reg};
                ovps_pkg::off_group_sel: prdata_next[2:0] = group_sel_reg;
                ovps_pkg::off_wiring: prdata_next[0] = two_line_aux_wiring;
                ovps_pkg::off_irq_status: prdata_next[7:0] = irq_status_reg;
                ovps_pkg::off_irq_enable: prdata_next[7:0] = irq_enable_reg;
                ovps_pkg::off_irq_clear: prdata_next = 32'h0;
                ovps_pkg::off_stage_status: prdata_next[11:0] = {pickup_reg, stage_status};
                default: map_hit = 1'b0;
            endcase
        end
        prdata = apb_rd ? prdata_next : 32'h0;
        pslverr = psel && penable && !map_hit;
    end
endmodule

/* dv/ovps_properties.sv */
// Purpose: Concurrent checks on the pick-up stage ports
// Assumes: Bound to ovps_stage with the same refresh_cycles
// Notes: Forcing is tracked as a sticky flag
`timescale 1ns/1ps
module ovps_checker #(
    parameter int unsigned refresh_cycles = 100
) (
    input wire logic clock, // Clock
    input wire logic rstn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire ovps_pkg::ovps_meas_type measured_magnitude, // Magnitudes
    input wire logic meas_valid, // Sample strobe
    input wire logic [7:0] stage_status, // Status pairs
    input wire logic [3:0] stage_pickup, // Pick-ups
    input wire logic irq // Interrupt
);
    logic [31:0] since_valid;
    logic force_seen;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clock) begin
        if (!rstn || meas_valid) begin
            since_valid <= 32'h0;
        end else if (since_valid != 32'hffffffff) begin
            since_valid <= since_valid + 32'h1;
        end
    end
    always_ff @(posedge clock) begin
        if (!rstn) begin
            force_seen <= 1'b0;
        end else if (psel && penable && pwrite && paddr == 8'h00 && pwdata[1]) begin
            force_seen <= 1'b1;
        end
    end
    sequence s_rise0;
        !stage_pickup[0] ##1 stage_pickup[0];
    endsequence
    a_ready_zero_wait:
        assert property (psel && penable |-> pready) else $error("no ready");
    a_idle_read_zero:
        assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read");
    a_global_mapped:
        assert property (psel && penable && paddr == 8'h00 |-> !pslverr)
        else $error("error on global word");
    a_reset_clears_out:
        assert property ($rose(rstn) |-> stage_status == 8'h00 && stage_pickup == 4'h0 && !irq)
        else $error("outputs not cleared by reset");
    a_pickup_on_eval:
        assert property ($changed(stage_pickup) |->
            since_valid <= 32'h0a || since_valid >= 2 * refresh_cycles - 10)
        else $error("pick-up moved outside evaluation");
    a_trip_needs_force:
        assert property (stage_status[1:0] == 2'h2 |-> force_seen) else $error("unforced trip");
    a_quiet_is_normal:
        assert property (!force_seen && !stage_pickup[0] |-> stage_status[1:0] == 2'h0)
        else $error("status without pick-up");
    a_rise_gives_status:
        assert property (s_rise0 |-> force_seen || stage_status[1:0] != 2'h0)
        else $error("pick-up without status");
endmodule

/* dv/ovps_meas_src.sv */
// Purpose: Measurement channel model feeding magnitude sets to the stage
// Assumes: One strobe every period cycles while run is high
// Notes: Values are inverted off the strobe so late sampling shows up
`timescale 1ns/1ps
module ovps_meas_src #(
    parameter int unsigned period = 40
) (
    input wire logic clock, // Clock
    input wire logic rstn, // Reset, active low
    input wire logic run, // Keep sending
    input wire ovps_pkg::ovps_meas_type level, // Magnitudes to present
    output ovps_pkg::ovps_meas_type measured_magnitude, // To the stage
    output logic meas_valid // One-cycle strobe
);
    int unsigned cnt;
    ovps_pkg::ovps_meas_type held;
    always_ff @(posedge clock) begin
        if (!rstn || !run || cnt == period - 1) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
        meas_valid <= rstn && run && cnt == period - 1;
        held <= level;
    end
    assign measured_magnitude = meas_valid ? held : ~held;
endmodule

/* dv/ovps_stage_tb.sv */
// Purpose: Self-checking bench for the four overvoltage pick-up stages
// Assumes: Zero-wait APB slave, samples every 40 cycles
// Notes: refresh_cycles is shortened so the sample timeout fits the run
`timescale 1ns/1ps
module ovps_stage_tb;
    localparam int unsigned rc = 100;
    localparam int unsigned per = 40;
    localparam logic [15:0] lo = 16'h0;
    localparam logic [15:0] hi = 16'h2af8;
    logic clock;
    logic rstn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic meas_valid;
    logic run;
    logic irq;
    logic e;
    logic [7:0] stage_status;
    logic [3:0] stage_pickup;
    logic [31:0] q;
    ovps_pkg::ovps_meas_type measured_magnitude;
    ovps_pkg::ovps_meas_type level;
    int failures = 0;
    int n_compared = 0;
    ovps_stage #(.refresh_cycles(rc)) i_ovps_stage (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .measured_magnitude(measured_magnitude),
        .meas_valid(meas_valid), .stage_status(stage_status), .stage_pickup(stage_pickup),
        .irq(irq));
    ovps_meas_src #(.period(per)) i_ovps_meas_src (.clock(clock), .rstn(rstn), .run(run),
        .level(level), .measured_magnitude(measured_magnitude), .meas_valid(meas_valid));
    task automatic summarize();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
        apb(1'b0, a, 32'h0);
        chk("register", q & m, x);
    endtask
    // Evaluation lands within 8 cycles of a strobe; two strobes cover any phase
    task automatic sm(input logic [15:0] a, b, c, ln, c3, c4, input logic [3:0] pk,
            input logic [7:0] st);
        @(posedge clock);
        level <= {a, b, c, ln, ln, ln, c3, c4};
        repeat (2 * per + 12) @(posedge clock);
        @(negedge clock);
        chk("pickup", 32'(stage_pickup), 32'(pk));
        chk("status", 32'(stage_status), 32'(st));
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        $display("timeout");
        summarize();
    end
    initial begin
        {rstn, psel, penable, pwrite, run, paddr, pwdata, level} = '0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        run <= 1'b1;
        rd(8'h00, 32'h3, 32'h0);
        rd(8'h40, 32'h3ff, 32'h0);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped", 32'(e), 32'h1);
        $display("reset test done");
        sm(16'h2904, 16'h2904, 16'h2904, lo, lo, lo, 4'h0, 8'h00);
        sm(16'h2905, lo, lo, lo, lo, lo, 4'hf, 8'h55);
        sm(16'h27c9, lo, lo, lo, lo, lo, 4'hf, 8'h55);
        sm(16'h27c8, lo, lo, lo, lo, lo, 4'h0, 8'h00);
        apb(1'b1, 8'h84, 32'h12710);
        apb(1'b1, 8'h88, 32'h22710);
        apb(1'b1, 8'h9c, 32'h01388);
        sm(16'h2774, 16'h2774, 16'h2328, lo, lo, lo, 4'h2, 8'h04);
        sm(16'h2774, 16'h2774, 16'h2774, lo, lo, lo, 4'h6, 8'h14);
        apb(1'b1, 8'h04, 32'h1);
        sm(16'h2774, 16'h2774, 16'h2774, lo, lo, lo, 4'h8, 8'h40);
        apb(1'b1, 8'h04, 32'h0);
        $display("threshold test done");
        apb(1'b1, 8'h40, 32'h300);
        sm(lo, lo, lo, lo, lo, hi, 4'h1, 8'h01);
        apb(1'b1, 8'h40, 32'h200);
        sm(lo, lo, lo, lo, hi, lo, 4'h0, 8'h00);
        apb(1'b1, 8'h08, 32'h1);
        sm(lo, lo, lo, lo, hi, lo, 4'h1, 8'h01);
        apb(1'b1, 8'h40, 32'h0);
        sm(lo, lo, hi, lo, lo, lo, 4'h0, 8'h00);
        sm(lo, hi, lo, lo, lo, lo, 4'h9, 8'h41);
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h40, 32'h100);
        sm(lo, lo, lo, hi, lo, lo, 4'h1, 8'h01);
        apb(1'b1, 8'h04, 32'h1);
        rd(8'h40, 32'h3ff, 32'h100);
        apb(1'b1, 8'h04, 32'h0);
        $display("source test done");
        apb(1'b1, 8'h40, 32'h101);
        rd(8'h40, 32'h3ff, 32'h100);
        apb(1'b1, 8'h00, 32'h1);
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, 8'h40, 32'h100 + 32'(m));
            rd(8'h40, 32'h3ff, 32'h100 + 32'(m));
        end
        apb(1'b1, 8'h40, 32'h101);
        sm(lo, lo, lo, hi, lo, lo, 4'h1, 8'h03);
        apb(1'b1, 8'h40, 32'h122);
        rd(8'h40, 32'h3ff, 32'h102);
        apb(1'b1, 8'h00, 32'h3);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, 8'h40, 32'h102 + 32'(m * 16));
            rd(8'h40, 32'h3ff, 32'h102 + 32'(m * 16));
        end
        apb(1'b1, 8'h40, 32'h122);
        sm(lo, lo, lo, hi, lo, lo, 4'h1, 8'h02);
        $display("mode test done");
        apb(1'b1, 8'h40, 32'h100);
        sm(lo, lo, lo, lo, lo, lo, 4'h0, 8'h00);
        apb(1'b1, 8'h14, 32'hff);
        rd(8'h0c, 32'hff, 32'h0);
        apb(1'b1, 8'h10, 32'h1);
        sm(lo, lo, lo, hi, lo, lo, 4'h1, 8'h01);
        chk("irq", 32'(irq), 32'h1);
        rd(8'h0c, 32'h1, 32'h1);
        apb(1'b1, 8'h10, 32'h0);
        @(negedge clock);
        chk("irq", 32'(irq), 32'h0);
        apb(1'b1, 8'h14, 32'h1);
        rd(8'h0c, 32'h1, 32'h0);
        rd(8'h14, 32'hff, 32'h0);
        $display("interrupt test done");
        @(posedge clock);
        run <= 1'b0;
        repeat (2 * rc + 20) @(posedge clock);
        @(negedge clock);
        chk("pickup", 32'(stage_pickup), 32'h0);
        $display("timeout test done");
        summarize();
    end
endmodule
bind ovps_stage ovps_checker #(.refresh_cycles(refresh_cycles)) i_ovps_checker (.clock(clock),
    .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .measured_magnitude(measured_magnitude), .meas_valid(meas_valid),
    .stage_status(stage_status), .stage_pickup(stage_pickup), .irq(irq));
